// ===== fisr_core.sv
`timescale 1ns/1ps
// ----------------------------------------
// Program byte buffer
// ----------------------------------------
module fisr_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] buf_mem [0:D-1];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   cnt_r;
  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;
  // Honest full and empty from the occupancy count
  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = buf_mem[rd_ptr_r];
  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) buf_mem[wr_ptr_r] <= in_data;
  end
  // Pointers wrap at depth
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (push) wr_ptr_r <= (wr_ptr_r == AW'(D-1)) ? '0 : wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= (rd_ptr_r == AW'(D-1)) ? '0 : rd_ptr_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ----------------------------------------
// Command interpreter
// ----------------------------------------
module fisr_core #(
  parameter int ERASE_CYC = fisr_pkg::ERASE_CYC_DEF
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Serial pins
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       serial_data_in,
  output logic            serial_data_out,
  output logic            serial_out_en_n,
  // Status and control
  input  wire logic       latch_set,
  input  wire logic [2:0] lock_set,
  output logic            write_enable_latch,
  output logic [2:0]      otp_lock_bits,
  output logic            busy_flag,
  output logic            prog_overrun
);
  import fisr_pkg::*;
  logic [7:0] mem [0:767];
  logic [2:0] in_s1_r;
  logic [2:0] in_s2_r;
  logic [1:0] edge_d_r;
  fisr_state_t st_r;
  fisr_state_t st_nxt;
  logic [5:0]  bitc_r;
  logic [22:0] shin_r;
  logic [7:0]  op_r;
  logic [7:0]  addr_r;
  logic [1:0]  sel_r;
  logic [7:0]  shout_r;
  logic [2:0]  obit_r;
  logic        so_r;
  logic        so_en_n_r;
  logic        busy_r;
  logic        latch_r;
  logic [2:0]  lock_r;
  logic        ovr_r;
  logic        prog_act_r;
  logic        er_act_r;
  logic [CNT_W-1:0] er_cnt_r;
  logic [5:0]  pcnt_r;
  logic        pop_v;
  logic [FIFO_W-1:0] pop_d;
  logic        push_rdy;

  // ----------------------------------------
  // Pin synchronisers, edges read only second stage
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_s1_r  <= 3'h5; // Deselected, clock parked low
      in_s2_r  <= 3'h5;
      edge_d_r <= 2'h2;
    end else begin
      in_s1_r  <= {cs_n, sclk, serial_data_in};
      in_s2_r  <= in_s1_r;
      edge_d_r <= in_s2_r[2:1];
    end
  end
  wire cs_low  = ~in_s2_r[2];
  wire din     = in_s2_r[0];
  wire rise_ev = cs_low & in_s2_r[1] & ~edge_d_r[0];
  wire fall_ev = cs_low & ~in_s2_r[1] & edge_d_r[0];
  wire cs_rise = in_s2_r[2] & ~edge_d_r[1];

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  function automatic logic [7:0] id_byte(input logic [7:0] a);
    id_byte = (a == 8'h00) ? ID_MFR : (a == 8'h01) ? ID_TYPE :
              (a == 8'h02) ? ID_CAP : 8'h00;
  endfunction
  // Table holds only a signature; remainder reads erased
  function automatic logic [7:0] ptab_byte(input logic [7:0] a);
    ptab_byte = (a[7:2] != 6'h00) ? ERASED : PTAB_SIG[(3 - a[1:0]) * 8 +: 8];
  endfunction
  wire [7:0]  byte_in  = {shin_r[6:0], din};
  wire [23:0] addr_in  = {shin_r, din};
  wire [3:0]  sel_fld  = addr_in[SEL_LSB +: 4];
  wire sec_ok = (addr_in[HI_LSB +: 8] == 8'h00) & (addr_in[MID_LSB +: 4] == 4'h0) &
                (sel_fld[3:2] == 2'b00) & (sel_fld[1:0] != 2'b00);
  wire [1:0]  sel_in   = sel_fld[1:0] - 2'b01;
  wire lock_hit  = lock_r[sel_in];
  wire wr_ok     = latch_r & ~lock_hit;
  wire [7:0] src_op  = (st_r == ST_CMD) ? byte_in : op_r;
  wire [7:0] src_a   = (st_r == ST_CMD) ? 8'h00 : (st_r == ST_OUT) ? addr_r + 8'h01 : addr_r;
  wire [7:0] src_b   = (src_op == OP_READ_ID) ? id_byte(src_a) :
                       (src_op == OP_READ_PTAB) ? ptab_byte(src_a) : mem[{sel_r, src_a}];
  wire out_load  = (st_nxt == ST_OUT) & (st_r != ST_OUT);
  wire out_next  = (st_r == ST_OUT) & fall_ev & (obit_r == 3'h7);
  wire push_v    = (st_r == ST_PDATA) & rise_ev & (bitc_r[2:0] == 3'h7);
  wire er_start  = cs_rise & (st_r == ST_ERWAIT);
  wire er_done   = er_act_r & (er_cnt_r == '0);
  wire pop_rdy   = (pcnt_r == 6'h00) & ~er_act_r;
  wire prog_done = prog_act_r & busy_r & ~pop_v & (pcnt_r == 6'h00);

  // ----------------------------------------
  // Command phase sequencing
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (!cs_low) begin
      st_nxt = ST_CMD;
    end else if (rise_ev) begin
      case (st_r)
        ST_CMD: begin
          if (bitc_r == OP_LAST) begin
            if (busy_r) st_nxt = ST_IGN;
            else if (byte_in == OP_READ_ID) st_nxt = ST_OUT;
            else if (byte_in == OP_READ_PTAB || byte_in == OP_READ_SEC ||
                     byte_in == OP_ERASE || byte_in == OP_PROG) st_nxt = ST_ADDR;
            else st_nxt = ST_IGN;
          end
        end
        ST_ADDR: begin
          if (bitc_r == ADDR_LAST) begin
            if (op_r == OP_READ_PTAB) st_nxt = ST_DUMMY;
            else if (!sec_ok) st_nxt = ST_IGN;
            else if (op_r == OP_READ_SEC) st_nxt = ST_DUMMY;
            else if (!wr_ok) st_nxt = ST_IGN;
            else if (op_r == OP_ERASE) st_nxt = ST_ERWAIT;
            else st_nxt = ST_PDATA;
          end
        end
        ST_DUMMY: begin
          if (bitc_r == DUMMY_LAST) st_nxt = ST_OUT;
        end
        ST_ERWAIT: st_nxt = ST_IGN;
        default: st_nxt = st_r;
      endcase
    end
  end
  // State, bit count and input shifter
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r   <= ST_CMD;
      bitc_r <= 6'h00;
      shin_r <= '0;
      op_r   <= 8'h00;
    end else begin
      st_r   <= st_nxt;
      bitc_r <= !cs_low ? 6'h00 : rise_ev ? bitc_r + 6'h01 : bitc_r;
      if (rise_ev) shin_r <= {shin_r[21:0], din};
      if (rise_ev && st_r == ST_CMD && bitc_r == OP_LAST) op_r <= byte_in;
    end
  end

  // ----------------------------------------
  // Byte address, register select and output shifter
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_r    <= 8'h00;
      sel_r     <= 2'h0;
      shout_r   <= 8'h00;
      obit_r    <= 3'h0;
      so_r      <= 1'b0;
      so_en_n_r <= 1'b1;
    end else begin
      if (rise_ev && st_r == ST_ADDR && bitc_r == ADDR_LAST) begin
        addr_r <= addr_in[7:0];
        sel_r  <= sel_in;
      end else if (out_next || push_v) begin
        addr_r <= addr_r + 8'h01;
      end else if (rise_ev && st_r == ST_CMD && bitc_r == OP_LAST) begin
        addr_r <= 8'h00;
      end
      // Drive on falling edges, MSB first
      if (out_load) begin
        shout_r <= src_b;
        obit_r  <= 3'h0;
      end else if (st_r == ST_OUT && fall_ev) begin
        so_r    <= shout_r[7];
        shout_r <= (obit_r == 3'h7) ? src_b : {shout_r[6:0], 1'b0};
        obit_r  <= obit_r + 3'h1;
      end
      so_en_n_r <= ~(st_nxt == ST_OUT);
    end
  end

  // ----------------------------------------
  // Busy, latch, locks and erase timer
  // ----------------------------------------
  // Set wins: a latch request during completion is kept
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_r     <= 1'b0;
      latch_r    <= LATCH_RST;
      lock_r     <= LOCK_RST;
      er_act_r   <= 1'b0;
      er_cnt_r   <= '0;
      prog_act_r <= 1'b0;
      ovr_r      <= 1'b0;
    end else begin
      lock_r <= lock_r | lock_set;
      if (er_start || (cs_rise && prog_act_r)) busy_r <= 1'b1;
      else if (er_done || prog_done) busy_r <= 1'b0;
      if (latch_set) latch_r <= 1'b1;
      else if (er_done || prog_done) latch_r <= 1'b0;
      if (er_start) begin
        er_act_r <= 1'b1;
        er_cnt_r <= CNT_W'(ERASE_CYC - 1);
      end else if (er_act_r) begin
        er_act_r <= ~er_done;
        er_cnt_r <= er_cnt_r - 1'b1;
      end
      if (push_v) prog_act_r <= 1'b1;
      else if (prog_done) prog_act_r <= 1'b0;
      if (st_r == ST_ADDR && st_nxt == ST_PDATA) ovr_r <= 1'b0;
      else if (push_v && !push_rdy) ovr_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Array writes: erase sweep or buffered program
  // ----------------------------------------
  // Program can only clear bits, so unerased bytes merge by AND
  always_ff @(posedge ref_clk) begin
    if (er_act_r) mem[{sel_r, er_cnt_r[7:0]}] <= ERASED;
    else if (pop_v && pop_rdy) mem[{sel_r, pop_d[7:0]}] <= mem[{sel_r, pop_d[7:0]}] & pop_d[15:8];
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) pcnt_r <= 6'h00;
    else if (pop_v && pop_rdy) pcnt_r <= 6'(BYTE_PROG_CYC - 1);
    else if (pcnt_r != 6'h00) pcnt_r <= pcnt_r - 6'h01;
  end
  fisr_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk       (ref_clk),
    .rst       (sys_rst),
    .in_valid  (push_v),
    .in_ready  (push_rdy),
    .in_data   ({byte_in, addr_r}),
    .out_valid (pop_v),
    .out_ready (pop_rdy),
    .out_data  (pop_d)
  );
  // Outputs straight from flip-flops
  assign serial_data_out    = so_r;
  assign serial_out_en_n    = so_en_n_r;
  assign write_enable_latch = latch_r;
  assign otp_lock_bits      = lock_r;
  assign busy_flag          = busy_r;
  assign prog_overrun       = ovr_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire op_end = (st_r == ST_CMD) & rise_ev & (bitc_r == OP_LAST);
  id_first_a: assert property (
    (op_end && !busy_r && byte_in == OP_READ_ID) |=> (st_r == ST_OUT && shout_r == ID_MFR))
    else $error("id read did not load manufacturer byte");
  dummy_len_a: assert property (
    (st_r == ST_OUT && $past(st_r) == ST_DUMMY) |-> bitc_r == DUMMY_LAST + 6'h01)
    else $error("data started at wrong clock");
  erase_gate_a: assert property (
    (st_r == ST_ADDR && st_nxt == ST_ERWAIT) |-> (latch_r && !lock_hit && sec_ok))
    else $error("erase accepted without latch or while locked");
  prog_gate_a: assert property (
    (st_r == ST_ADDR && st_nxt == ST_PDATA) |-> (latch_r && !lock_hit && sec_ok))
    else $error("program accepted without latch or while locked");
  erase_exact_a: assert property (
    $rose(er_act_r) |-> $past(st_r) == ST_ERWAIT && $past(cs_rise))
    else $error("erase began without exact select rise");
  busy_hold_a: assert property (
    $rose(er_act_r) |-> busy_r [*8])
    else $error("busy dropped early in erase");
  latch_clear_a: assert property (
    (er_done && !latch_set) |=> (!latch_r && !busy_r))
    else $error("latch or busy kept after erase");
  busy_ignore_a: assert property (
    (op_end && busy_r) |=> st_r == ST_IGN)
    else $error("command taken while busy");
  ignore_keep_a: assert property (
    (cs_rise && st_r == ST_IGN && !busy_r) |=> (!busy_r && latch_r == $past(latch_r | latch_set)))
    else $error("ignored command changed busy or latch");
  addr_wrap_a: assert property (
    (out_next && addr_r == 8'hFF) |=> addr_r == 8'h00)
    else $error("read address failed to wrap");
  id_cov: cover property (op_end && byte_in == OP_READ_ID && !busy_r);
  erase_cov: cover property (er_done);
  prog_cov: cover property (prog_done);
  ptab_cov: cover property (out_load && op_r == OP_READ_PTAB);
endmodule

// ===== fisr_pkg.sv
package fisr_pkg;
  // ----------------------------------------
  // Opcodes and phase ends
  // ----------------------------------------
  localparam logic [7:0] OP_READ_ID   = 8'h9F;
  localparam logic [7:0] OP_READ_PTAB = 8'h5A;
  localparam logic [7:0] OP_ERASE     = 8'h44;
  localparam logic [7:0] OP_PROG      = 8'h42;
  localparam logic [7:0] OP_READ_SEC  = 8'h48;
  localparam logic [5:0] OP_LAST      = 6'h07;
  localparam logic [5:0] ADDR_LAST    = 6'h1F;
  localparam logic [5:0] DUMMY_LAST   = 6'h27;
  // ----------------------------------------
  // Address fields
  // ----------------------------------------
  localparam int SEL_LSB = 12;
  localparam int HI_LSB  = 16;
  localparam int MID_LSB = 8;
  // ----------------------------------------
  // Identity (values arbitrary) and table signature (arbitrary)
  // ----------------------------------------
  localparam logic [7:0]  ID_MFR   = 8'h5C;
  localparam logic [7:0]  ID_TYPE  = 8'h6B;
  localparam logic [7:0]  ID_CAP   = 8'h2D;
  localparam logic [31:0] PTAB_SIG = 32'hA5C3961E;
  localparam logic [7:0]  ERASED   = 8'hFF;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic       LATCH_RST = 1'b0;
  localparam logic [2:0] LOCK_RST  = 3'h0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ       = 10;
  localparam int ERASE_TIME_US = 1000;
  localparam int ERASE_CYC_DEF = ERASE_TIME_US * CLK_MHZ;
  localparam int BYTE_PROG_US  = 3;
  localparam int BYTE_PROG_CYC = BYTE_PROG_US * CLK_MHZ;
  localparam int CNT_W         = 24;
  // ----------------------------------------
  // Buffer shape and states
  // ----------------------------------------
  localparam int FIFO_W = 16;
  localparam int FIFO_D = 8;
  typedef enum logic [2:0] {
    ST_CMD    = 3'b000,
    ST_ADDR   = 3'b001,
    ST_DUMMY  = 3'b010,
    ST_OUT    = 3'b011,
    ST_PDATA  = 3'b100,
    ST_ERWAIT = 3'b101,
    ST_IGN    = 3'b110
  } fisr_state_t;
endpackage

// ===== fisr_host_model.sv
`timescale 1ns/1ps
// ----
// Host serial controller, mode 0, MSB first
// ----
module fisr_host_model #(
  parameter int H = 6
) (
  // Clock
  input  wire logic ref_clk,
  // Serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      serial_data_in,
  input  wire logic serial_data_out
);
  // Idle: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    serial_data_in = 1'b0;
  end

  // Select low before any clock
  task automatic open_frame();
    @(posedge ref_clk);
    cs_n <= 1'b0;
    repeat (H) @(posedge ref_clk);
  endtask

  // Data set while clock low, sampled at the rise
  task automatic shift(input int n, input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      serial_data_in <= tx[i];
      repeat (H) @(posedge ref_clk);
      rx = {rx[6:0], serial_data_out};
      sclk <= 1'b1;
      repeat (H) @(posedge ref_clk);
      sclk <= 1'b0;
    end
  endtask

  // Opcode then 24 address bits, select kept low
  task automatic cmd(input logic [7:0] op, input logic [23:0] a);
    logic [7:0] rx;
    open_frame();
    shift(8, op, rx);
    for (int k = 2; k >= 0; k--) begin
      shift(8, a[k*8 +: 8], rx);
    end
  endtask

  // Deselect right after the last bit; data line left toggled, not held
  task automatic close_frame();
    repeat (H) @(posedge ref_clk);
    cs_n <= 1'b1;
    serial_data_in <= ~serial_data_in;
    repeat (H) @(posedge ref_clk);
  endtask
endmodule

// ===== flash_id_and_security_regs_tb_top.sv
`timescale 1ns/1ps
module flash_id_and_security_regs_tb_top;
  import fisr_pkg::*;
  typedef logic [7:0] fisr_bytes_t [4];
  // ----
  // Signals
  // ----
  logic       ref_clk;
  logic       sys_rst;
  logic       latch_set;
  logic [2:0] lock_set;
  logic       cs_n;
  logic       sclk;
  logic       sdi;
  logic       sdo;
  logic       oe_n;
  logic       latch;
  logic       busy;
  logic       ovr;
  logic [2:0] locks;
  int         fails;
  int         samples_checked;

  // 10 MHz clock
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  // Erase kept short but above the 256-byte sweep
  fisr_core #(.ERASE_CYC(1000)) uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk),
    .serial_data_in(sdi), .serial_data_out(sdo), .serial_out_en_n(oe_n),
    .latch_set(latch_set), .lock_set(lock_set), .write_enable_latch(latch),
    .otp_lock_bits(locks), .busy_flag(busy), .prog_overrun(ovr)
  );
  fisr_host_model #(.H(6)) host (
    .ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk),
    .serial_data_in(sdi), .serial_data_out(sdo)
  );

  // ----
  // Helpers
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic pulse_latch();
    @(posedge ref_clk);
    latch_set <= 1'b1;
    @(posedge ref_clk);
    latch_set <= 1'b0;
  endtask

  // Bounded wait: erase is 1000 cycles, never more than 2000
  task automatic wait_idle();
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge ref_clk);
    chk({7'h0, busy}, 8'h00, "busy stuck");
  endtask

  // Opcode, address, eight dummies, then four bytes
  task automatic rd_chk(input logic [7:0] op, input logic [23:0] a, input fisr_bytes_t e);
    logic [7:0] rx;
    host.cmd(op, a);
    host.shift(8, 8'h00, rx);
    for (int i = 0; i < 4; i++) begin
      host.shift(8, 8'h00, rx);
      chk(rx, e[i], "read byte");
    end
    host.close_frame();
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_id();
    logic [7:0] rx;
    fisr_bytes_t e = '{ID_MFR, ID_TYPE, ID_CAP, 8'h00};
    host.open_frame();
    host.shift(8, OP_READ_ID, rx);
    for (int i = 0; i < 3; i++) begin
      host.shift(8, 8'h00, rx);
      chk(rx, e[i], "id byte");
    end
    chk({7'h0, oe_n}, 8'h00, "output enable");
    host.close_frame();
    $display("test id done");
  endtask

  // Start near the top so the wrap to the signature is seen
  task automatic t_ptab();
    rd_chk(OP_READ_PTAB, 24'h0000FE, '{ERASED, ERASED, PTAB_SIG[31:24], PTAB_SIG[23:16]});
    $display("test table done");
  endtask

  task automatic t_erase(input logic [3:0] sel);
    pulse_latch();
    host.cmd(OP_ERASE, {8'h00, sel, 4'h0, 8'h5A});
    host.close_frame();
    chk({7'h0, busy}, 8'h01, "erase busy");
    wait_idle();
    chk({7'h0, latch}, 8'h00, "latch after erase");
    rd_chk(OP_READ_SEC, {8'h00, sel, 12'h0FE}, '{ERASED, ERASED, ERASED, ERASED});
    $display("test erase done");
  endtask

  // Three bytes from FEh wrap into 00h
  task automatic t_prog();
    logic [7:0] rx;
    fisr_bytes_t d = '{8'h12, 8'h34, 8'h56, 8'h00};
    pulse_latch();
    host.cmd(OP_PROG, 24'h0020FE); // register 2 was erased by t_erase
    for (int i = 0; i < 3; i++) host.shift(8, d[i], rx);
    host.close_frame();
    chk({7'h0, busy}, 8'h01, "program busy");
    wait_idle();
    chk({7'h0, latch}, 8'h00, "latch after program");
    chk({7'h0, ovr}, 8'h00, "program overrun");
    rd_chk(OP_READ_SEC, 24'h0020FE, '{8'h12, 8'h34, 8'h56, ERASED});
    $display("test program done");
  endtask

  // Read issued mid-erase must stay silent
  task automatic t_busy();
    logic [7:0] rx;
    pulse_latch();
    host.cmd(OP_ERASE, 24'h001000);
    host.close_frame();
    host.cmd(OP_READ_SEC, 24'h001000);
    host.shift(8, 8'h00, rx);
    host.shift(8, 8'h00, rx);
    chk({7'h0, oe_n}, 8'h01, "read during busy");
    chk({7'h0, busy}, 8'h01, "erase kept");
    host.close_frame();
    wait_idle();
    $display("test busy done");
  endtask

  // Refusals: no latch, extra clock, locked register
  task automatic t_refuse();
    logic [7:0] rx;
    host.cmd(OP_ERASE, 24'h002000);
    host.close_frame();
    chk({7'h0, busy}, 8'h00, "erase without latch");
    pulse_latch();
    host.cmd(OP_ERASE, 24'h002000);
    host.shift(1, 8'h00, rx);
    host.close_frame();
    chk({7'h0, busy}, 8'h00, "erase with extra clock");
    chk({7'h0, latch}, 8'h01, "latch kept");
    host.cmd(OP_ERASE, 24'h004000);
    host.close_frame();
    chk({7'h0, busy}, 8'h00, "erase bad address");
    @(posedge ref_clk);
    lock_set <= 3'b010;
    @(posedge ref_clk);
    lock_set <= 3'b000;
    repeat (2) @(posedge ref_clk);
    chk({5'h0, locks}, 8'h02, "lock bits");
    host.cmd(OP_PROG, 24'h0020FE);
    host.shift(8, 8'h00, rx);
    host.close_frame();
    chk({7'h0, busy}, 8'h00, "locked program");
    host.cmd(OP_ERASE, 24'h002000);
    host.close_frame();
    chk({7'h0, busy}, 8'h00, "locked erase");
    chk({7'h0, latch}, 8'h01, "latch kept locked");
    rd_chk(OP_READ_SEC, 24'h0020FE, '{8'h12, 8'h34, 8'h56, ERASED});
    $display("test refuse done");
  endtask

  // ----
  // Verdict
  // ----
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    fails = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    latch_set = 1'b0;
    lock_set = 3'b000;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({4'h0, busy, latch, oe_n, 1'b0}, 8'h02, "reset levels");
    t_id();
    t_ptab();
    t_erase(4'h2);
    t_prog();
    t_busy();
    t_refuse();
    tally_and_finish();
  end

  // Watchdog, about six times the expected run
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
